// ===== pwm_auto_reload_timer.sv
`default_nettype none
`include "art_consts.svh"
module pwm_auto_reload_timer
  import art_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Low-power state of the surrounding controller
  input  wire logic        halt_mode,
  // External pins
  input  wire logic        external_clock_input,
  input  wire logic [1:0]  capture_input_pin,
  output logic [3:0]       pwm_output_pin,
  output logic [3:0]       pwm_output_oe,
  // Requests toward the interrupt controller
  output logic             overflow_irq,
  output logic             capture_irq,
  output logic             wake_irq
);

  // Register state
  ctrl_status_s csr_reg;
  pwm_ctrl_s    pwm_output_control_reg;
  cap_ctrl_s    iccsr_reg;
  byte_t        reload_reg;
  byte_t        cnt_reg;
  logic [6:0]   pre_reg;
  byte_t        duty_reg [4];
  byte_t        comp_reg [4];
  byte_t        icr_reg  [2];
  logic [3:0]   wave_reg;
  logic [3:0]   pin_reg;
  logic         wake_reg;

  // Bus state
  logic         wr_pend_reg;
  logic [7:0]   wr_idx_reg;
  logic [31:0]  rdata_reg;

  // Decoding shared by read and write paths
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] idx);
    hit = (addr[31:10] == 22'h0) && (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic [7:0] addr_idx(input logic [31:0] addr);
    addr_idx = addr[9:2];
  endfunction

  // Pin synchronisers: external clock and two capture inputs
  logic [2:0] pin_in;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pin_in = {capture_input_pin, external_clock_input};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      pin_sync u_sync
      (
        .clk  (clk),
        .rst  (rst),
        .pin  (pin_in[g]),
        .rise (pin_rise[g]),
        .fall (pin_fall[g])
      );
    end
  endgenerate

  // Bus phases
  logic       addr_ok;
  logic       rd_take;
  logic       wr_take;
  logic [7:0] wdata;

  assign addr_ok   = hsel & htrans[1] & hready;
  assign rd_take   = addr_ok & ~hwrite;
  assign wr_take   = addr_ok & hwrite;
  assign wdata     = hwdata[7:0];
  assign hreadyout = 1'b1; // Zero wait states; master idles in data phase
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // Write strobes, data phase of a latched write
  logic       wr_csr;
  logic       wr_car;
  logic       wr_arr;
  logic       wr_pwm_output_control;
  logic       wr_iccsr;
  logic [3:0] wr_duty;

  assign wr_csr   = wr_pend_reg & (wr_idx_reg == `IDX_CSR);
  assign wr_car   = wr_pend_reg & (wr_idx_reg == `IDX_CAR);
  assign wr_arr   = wr_pend_reg & (wr_idx_reg == `IDX_ARR);
  assign wr_pwm_output_control = wr_pend_reg & (wr_idx_reg == `IDX_PWM_OUTPUT_CONTROL);
  assign wr_iccsr = wr_pend_reg & (wr_idx_reg == `IDX_ICCSR);
  assign wr_duty  = {wr_pend_reg & (wr_idx_reg == `IDX_DUTY3),
                     wr_pend_reg & (wr_idx_reg == `IDX_DUTY2),
                     wr_pend_reg & (wr_idx_reg == `IDX_DUTY1),
                     wr_pend_reg & (wr_idx_reg == `IDX_DUTY0)};

  // Read strobes with side effects, taken in the address phase
  logic       rd_csr;
  logic [1:0] rd_icr;

  assign rd_csr = rd_take & hit(haddr, `IDX_CSR);
  assign rd_icr = {rd_take & hit(haddr, `IDX_ICR2), rd_take & hit(haddr, `IDX_ICR1)};

  // Force reload only when a one lands in the write-only bit
  logic force_ld;
  assign force_ld = wr_csr & wdata[`CSR_FORCE_BIT];

  // Prescaler input and division tap
  logic       in_tick;
  logic       run;
  logic       step;
  logic [6:0] tap_mask;
  logic       pre_done;
  logic       cnt_tick;
  logic       ovf_evt;

  // External events count only when synchronised; CPU clock ticks every cycle
  assign in_tick  = csr_reg.clock_source_select ? pin_rise[0] : 1'b1;
  // Halt drops the run enable, so nothing counts and PWM freezes
  assign run      = csr_reg.counter_enable & ~halt_mode;
  assign step     = run & in_tick;
  assign tap_mask = 7'((8'h01 << csr_reg.prescale_divider) - 8'h01);
  assign pre_done = ((pre_reg & tap_mask) == tap_mask);
  assign cnt_tick = step & pre_done;
  assign ovf_evt  = cnt_tick & (cnt_reg == `CNT_TOP);

  // Next prescaler; software counter loads restart it from zero
  logic [6:0] pre_next;
  always_comb
  begin
    if (force_ld | wr_car)
      pre_next = 7'h00;
    else if (step)
      pre_next = pre_reg + 7'h01;
    else
      pre_next = pre_reg;
  end

  // Next counter; software write beats hardware count
  byte_t cnt_next;
  always_comb
  begin
    if (wr_car)
      cnt_next = wdata;
    else if (force_ld)
      cnt_next = reload_reg;
    else if (ovf_evt)
      cnt_next = reload_reg;
    else if (cnt_tick)
      cnt_next = cnt_reg + 8'h01;
    else
      cnt_next = cnt_reg;
  end

  // Counter, prescaler and reload
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_reg    <= 7'h00;
      cnt_reg    <= `RST_BYTE;
      reload_reg <= `RST_BYTE;
    end
    else
    begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      if (wr_arr)
        reload_reg <= wdata;
    end
  end

  // Control/status; a set in the same cycle as the clearing read wins
  logic ovf_next;
  assign ovf_next = ovf_evt | (csr_reg.overflow_flag & ~rd_csr);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      csr_reg <= ctrl_status_s'(`RST_BYTE);
    else
    begin
      if (wr_csr)
      begin
        csr_reg.clock_source_select <= wdata[7];
        csr_reg.prescale_divider    <= wdata[6:4];
        csr_reg.counter_enable      <= wdata[3];
        csr_reg.overflow_irq_enable <= wdata[1];
      end
      csr_reg.force_reload  <= 1'b0;
      csr_reg.overflow_flag <= ovf_next;
    end
  end

  // PWM output control register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_output_control_reg <= pwm_ctrl_s'(`RST_BYTE);
    else if (wr_pwm_output_control)
      pwm_output_control_reg <= pwm_ctrl_s'(wdata);
  end

  // Per channel: duty, hidden compare and the raw waveform state
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          duty_reg[g] <= `RST_BYTE;
          comp_reg[g] <= `RST_BYTE;
          wave_reg[g] <= 1'b0;
        end
        else
        begin
          if (wr_duty[g])
            duty_reg[g] <= wdata;
          // Compare only changes at overflow, so a duty edit never glitches
          if (ovf_evt)
            comp_reg[g] <= duty_reg[g];
          if (ovf_evt)
            wave_reg[g] <= 1'b1;
          else if (cnt_tick && (cnt_reg == comp_reg[g]))
            wave_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Pin level: polarity applies at once, disabled pins drive low
  logic [3:0] pin_next;
  assign pin_next = (wave_reg ^ pwm_output_control_reg.channel_polarity)
                    & pwm_output_control_reg.output_enable;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_reg <= 4'h0;
    else
      pin_reg <= pin_next;
  end

  assign pwm_output_pin = pin_reg;
  assign pwm_output_oe  = pwm_output_control_reg.output_enable;

  // Capture edges, gated by the lock that a pending flag holds
  logic [1:0] cap_edge;
  logic [1:0] cap_evt;
  logic [1:0] cf_next;

  generate
    for (g = 0; g < 2; g++)
    begin : g_cap
      assign cap_edge[g] = iccsr_reg.capture_edge_select[g]
                           ? pin_rise[g+1] : pin_fall[g+1];
      // Locked while pending; an edge in the clearing read cycle still lands, set wins
      assign cap_evt[g]  = cap_edge[g] & (~iccsr_reg.capture_flag[g] | rd_icr[g]);
      assign cf_next[g]  = cap_evt[g]
                           | (iccsr_reg.capture_flag[g] & ~rd_icr[g]);

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          icr_reg[g] <= `RST_BYTE;
        else if (cap_evt[g])
          icr_reg[g] <= cnt_reg;
      end
    end
  endgenerate

  // Capture control/status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      iccsr_reg <= cap_ctrl_s'(`RST_BYTE);
    else
    begin
      if (wr_iccsr)
      begin
        iccsr_reg.capture_edge_select <= wdata[5:4];
        iccsr_reg.capture_irq_enable  <= wdata[3:2];
      end
      iccsr_reg.capture_flag <= cf_next;
    end
  end

  // Wake pulse: any enabled edge while halted
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_reg <= 1'b0;
    else
      wake_reg <= halt_mode & |(cap_edge & iccsr_reg.capture_irq_enable);
  end

  assign wake_irq     = wake_reg;
  assign overflow_irq = csr_reg.overflow_flag & csr_reg.overflow_irq_enable;
  assign capture_irq  = |(iccsr_reg.capture_flag & iccsr_reg.capture_irq_enable);

  // Read mux; the write-only bit and reserved bits read zero
  byte_t rd_byte;
  always_comb
  begin
    unique case (addr_idx(haddr))
      `IDX_DUTY3: rd_byte = duty_reg[3];
      `IDX_DUTY2: rd_byte = duty_reg[2];
      `IDX_DUTY1: rd_byte = duty_reg[1];
      `IDX_DUTY0: rd_byte = duty_reg[0];
      `IDX_PWM_OUTPUT_CONTROL: rd_byte = pwm_output_control_reg;
      `IDX_CSR:   rd_byte = {csr_reg[7:3], 1'b0, csr_reg[1:0]};
      `IDX_CAR:   rd_byte = cnt_reg;
      `IDX_ARR:   rd_byte = reload_reg;
      `IDX_ICCSR: rd_byte = {2'b00, iccsr_reg[5:0]};
      `IDX_ICR1:  rd_byte = icr_reg[0];
      `IDX_ICR2:  rd_byte = icr_reg[1];
      default:    rd_byte = 8'h00;
    endcase
  end

  // Bus registers: read data captured at the address phase edge
  logic rd_mapped;
  assign rd_mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rdata_reg   <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= wr_take & (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'b00);
      wr_idx_reg  <= addr_idx(haddr);
      if (rd_take)
        rdata_reg <= {24'h0, rd_mapped ? rd_byte : 8'h00};
    end
  end

endmodule
`default_nettype wire

// ===== art_consts.svh
`ifndef ART_CONSTS_SVH
`define ART_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_DUTY3      8'h73
`define IDX_DUTY2      8'h74
`define IDX_DUTY1      8'h75
`define IDX_DUTY0      8'h76
`define IDX_PWM_OUTPUT_CONTROL      8'h77
`define IDX_CSR        8'h78
`define IDX_CAR        8'h79
`define IDX_ARR        8'h7a
`define IDX_ICCSR      8'h7b
`define IDX_ICR1       8'h7c
`define IDX_ICR2       8'h7d

// Field positions in the control/status register
`define CSR_FORCE_BIT  2

// Reset value and counter top
`define RST_BYTE       8'h00
`define CNT_TOP        8'hff

`endif

// ===== art_pkg.sv
`default_nettype none
package art_pkg;

  typedef logic [7:0] byte_t;

  // Control/status register layout, bit 7 first
  typedef struct packed {
    logic       clock_source_select;
    logic [2:0] prescale_divider;
    logic       counter_enable;
    logic       force_reload;
    logic       overflow_irq_enable;
    logic       overflow_flag;
  } ctrl_status_s;

  // PWM output control layout
  typedef struct packed {
    logic [3:0] output_enable;
    logic [3:0] channel_polarity;
  } pwm_ctrl_s;

  // Capture control/status layout
  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] capture_edge_select;
    logic [1:0] capture_irq_enable;
    logic [1:0] capture_flag;
  } cap_ctrl_s;

endpackage
`default_nettype wire

// ===== pin_sync.sv
`default_nettype none
module pin_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic       level_reg;
  logic       agree;
  logic [1:0] fill_reg;
  logic       armed;

  // Three-stage synchroniser; only s2 reads s1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      fill_reg  <= 2'h0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (!armed)
        fill_reg <= fill_reg + 2'h1;
      // Level primes from the pin, so a pin idling high gives no edge after reset
      if (!armed)
        level_reg <= s2_reg;
      else if (agree)
        level_reg <= s3_reg;
    end
  end

  // Edges count only once the chain holds real pin samples
  assign armed = (fill_reg == 2'h3);

  // A change counts once stages two and three agree, exactly once
  assign agree = (s2_reg == s3_reg);
  assign rise  = armed & agree & s3_reg & ~level_reg;
  assign fall  = armed & agree & ~s3_reg & level_reg;

endmodule
`default_nettype wire

// ===== art_assertions.sv
`default_nettype none
`include "art_consts.svh"
module art_checker
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        halt_mode,
  input wire logic [1:0]  capture_input_pin,
  input wire logic [3:0]  pwm_output_pin,
  input wire logic [3:0]  pwm_output_oe,
  input wire logic        wake_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Transfers taken at this edge; the one slave's answer is the bus ready
  wire logic tk     = hsel && htrans[1] && hreadyout;
  wire logic rd_csr = tk && !hwrite && haddr == {22'h0, `IDX_CSR, 2'h0};
  wire logic wr_pwm = tk && hwrite && haddr == {22'h0, `IDX_PWM_OUTPUT_CONTROL, 2'h0};

  AST_ZERO_WAIT_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  AST_BYTE_READ: assert property (tk && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  AST_FORCE_READS_ZERO: assert property (rd_csr |=> !hrdata[2])
    else $error("force reload bit read as one");
  // Pin driver off leaves the pin low, one cycle of lag allowed
  AST_PIN_OFF: assert property
    ((pwm_output_pin & ~pwm_output_oe & ~$past(pwm_output_oe)) == 4'h0)
    else $error("disabled channel drives high");
  AST_OE_BY_WRITE: assert property ($changed(pwm_output_oe) |-> $past(wr_pwm, 2))
    else $error("output enable changed without a write");
  AST_HALT_FREEZE: assert property
    ((halt_mode && !hsel) [*4] |=> $stable(pwm_output_pin))
    else $error("waveform moved during halt");
  AST_WAKE_IN_HALT: assert property (wake_irq |-> $past(halt_mode))
    else $error("wake outside halt");
  AST_WAKE_PULSE: assert property (wake_irq |=> !wake_irq)
    else $error("wake longer than one cycle");
  AST_WAKE_NEEDS_EDGE: assert property
    ($stable(capture_input_pin) [*8] |-> !wake_irq)
    else $error("wake without a pin edge");

  cover property (wake_irq);
  cover property (rd_csr);
  cover property ($rose(pwm_output_pin[0]));
endmodule

bind pwm_auto_reload_timer art_checker chk_u
(
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hreadyout, .hresp,
  .hrdata, .halt_mode, .capture_input_pin, .pwm_output_pin, .pwm_output_oe,
  .wake_irq
);
`default_nettype wire

// ===== art_pins_model.sv
`default_nettype none
module art_pins_model
(
  input  wire logic       clk,
  input  wire logic [3:0] pwm_output_pin,
  input  wire logic [3:0] pwm_output_oe,
  output logic            external_clock_input,
  output logic [1:0]      capture_input_pin,
  output logic [3:0]      load_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Loads are pulled down where the driver is off
  assign load_level = pwm_output_pin & pwm_output_oe;

  // Event clock idles low; channel 2 input idles high
  initial
  begin
    external_clock_input = 1'h0;
    capture_input_pin = 2'h2;
  end

  // Slow pulses, so none is lost in the synchroniser
  task automatic ext_pulses(int n);
    repeat (n)
    begin
      @(posedge clk);
      external_clock_input <= 1'h1;
      repeat (3) @(posedge clk);
      external_clock_input <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask

  // New pin levels, then time for the edge to act
  task automatic cap_set(logic [1:0] lv);
    @(posedge clk);
    capture_input_pin <= lv;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
`default_nettype none
`include "art_consts.svh"
`define CHK(n, e, g) chk(n, e, g)
module tb import art_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic        halt_mode = 1'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        external_clock_input;
  logic [1:0]  capture_input_pin;
  logic [3:0]  pwm_output_pin;
  logic [3:0]  pwm_output_oe;
  logic [3:0]  load_level;
  logic        overflow_irq;
  logic        capture_irq;
  logic        wake_irq;
  wire logic   hready = hreadyout;
  int          err_total = 0;
  int          num_checks = 0;
  int          wakes = 0;
  byte_t       v;
  logic [15:0] hits;

  pwm_auto_reload_timer dut_u
  (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .halt_mode, .external_clock_input,
    .capture_input_pin, .pwm_output_pin, .pwm_output_oe, .overflow_irq,
    .capture_irq, .wake_irq
  );
  art_pins_model pins_u
  (
    .clk, .pwm_output_pin, .pwm_output_oe, .external_clock_input,
    .capture_input_pin, .load_level
  );

  // 125 MHz
  always #4 clk = ~clk;
  always @(posedge clk) if (wake_irq === 1'h1) wakes++;

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait for hready; a stuck slave ends the run
  task automatic rdy();
    int n;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (hreadyout === 1'h1) break;
    end
    if (n == 50)
    begin
      err_total++;
      report_and_stop();
    end
  endtask

  // One single word transfer, idle in the data phase
  task automatic xfer(logic w, byte_t a, byte_t d, output byte_t r);
    hsel <= 1'h1;
    haddr <= {22'h0, a, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= {24'h0, d};
    rdy();
    r = hrdata[7:0];
  endtask

  task automatic wr(byte_t a, byte_t d);
    xfer(1'h1, a, d, v);
  endtask

  task automatic rd(byte_t a, output byte_t r);
    xfer(1'h0, a, 8'h00, r);
  endtask

  task automatic rdc(byte_t a, byte_t e);
    byte_t r;
    rd(a, r);
    `CHK("register", e, r);
  endtask

  // Counter advance between two reads taken k+2 cycles apart
  task automatic gap(int k, byte_t d);
    byte_t a;
    byte_t b;
    rd(`IDX_CAR, a);
    cyc(k);
    rd(`IDX_CAR, b);
    b = b - a;
    `CHK("count step", d, b);
  endtask

  // A level wait that used up its bound ends the run as a failure
  task automatic lim(int n);
    if (n >= 40)
    begin
      err_total++;
      report_and_stop();
    end
  endtask

  // Cycles out of n at which channel 0 drives high
  task automatic duty_hits(int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n)
    begin
      @(posedge clk);
      c = c + 16'(pwm_output_pin[0]);
    end
  endtask

  // High and low run lengths of one loaded channel
  task automatic pw(int ch, int hi, int lo);
    int h;
    int l;
    for (h = 0; h < 40 && load_level[ch] !== 1'h0; h++) @(posedge clk);
    lim(h);
    for (h = 0; h < 40 && load_level[ch] !== 1'h1; h++) @(posedge clk);
    lim(h);
    for (h = 0; h < 40 && load_level[ch] === 1'h1; h++) @(posedge clk);
    lim(h);
    for (l = 0; l < 40 && load_level[ch] === 1'h0; l++) @(posedge clk);
    lim(l);
    `CHK("high run", hi, h);
    `CHK("low run", lo, l);
  endtask

  initial
  begin
    cyc(6);
    rst <= 1'h0;
    // Reset values, then an unmapped word
    for (byte_t a = `IDX_DUTY3; a <= 8'h7e; a++)
      rdc(a, 8'h00);
    wr(8'h7e, 8'h5a);
    rdc(8'h7e, 8'h00);
    wr(`IDX_CSR, 8'hf7);
    rdc(`IDX_CSR, 8'hf2);
    // Every divider tap: four steps in 4 * 2^n cycles
    for (int n = 0; n < 8; n++)
    begin
      wr(`IDX_CSR, {1'h0, n[2:0], 4'h8});
      gap((4 << n) - 2, 8'h04);
    end
    wr(`IDX_CSR, 8'h08);
    halt_mode <= 1'h1;
    gap(20, 8'h00);
    halt_mode <= 1'h0;
    wr(`IDX_CSR, 8'h00);
    gap(20, 8'h00);
    // PWM: reload f0 gives a period of 16 on channels 0, 1 and 3; channel 2 stays disabled
    wr(`IDX_ARR, 8'hf0);
    wr(`IDX_DUTY0, 8'hf8);
    wr(`IDX_DUTY1, 8'hf8);
    wr(`IDX_DUTY3, 8'hf4);
    wr(`IDX_PWM_OUTPUT_CONTROL, 8'hb2);
    wr(`IDX_CSR, 8'h0c);
    cyc(40);
    pw(0, 9, 7);
    pw(1, 7, 9);
    pw(3, 5, 11);
    `CHK("enables", 4'hb, pwm_output_oe);
    `CHK("channel 2", 1'h0, pwm_output_pin[2]);
    wr(`IDX_DUTY0, 8'hf2);
    pw(0, 3, 13);
    // Halt with the waveform running; the checker sees the pins freeze
    halt_mode <= 1'h1;
    cyc(12);
    halt_mode <= 1'h0;
    // Finest step: reload 0, duty ff; polarity alone gives 100% then 0%
    wr(`IDX_DUTY0, 8'hff);
    wr(`IDX_ARR, 8'h00);
    cyc(24);
    duty_hits(300, hits);
    `CHK("full duty", 16'h012c, hits);
    wr(`IDX_PWM_OUTPUT_CONTROL, 8'hb3);
    cyc(2);
    duty_hits(300, hits);
    `CHK("zero duty", 16'h0000, hits);
    // Event mode: three external edges to overflow
    wr(`IDX_ARR, 8'hfd);
    wr(`IDX_CSR, 8'h8e);
    rd(`IDX_CSR, v);
    pins_u.ext_pulses(2);
    `CHK("early overflow", 1'h0, overflow_irq);
    pins_u.ext_pulses(1);
    cyc(4);
    `CHK("overflow irq", 1'h1, overflow_irq);
    rdc(`IDX_CSR, 8'h8b);
    `CHK("overflow clear", 1'h0, overflow_irq);
    // Capture: channel 1 rising, channel 2 falling
    wr(`IDX_CSR, 8'h00);
    wr(`IDX_CAR, 8'h55);
    wr(`IDX_ICCSR, 8'h1c);
    pins_u.cap_set(2'h3);
    `CHK("capture irq", 1'h1, capture_irq);
    wr(`IDX_CAR, 8'h66);
    pins_u.cap_set(2'h0);
    wr(`IDX_CAR, 8'h77);
    pins_u.cap_set(2'h1);
    wr(`IDX_ICCSR, 8'h10);
    rdc(`IDX_ICCSR, 8'h13);
    `CHK("capture masked", 1'h0, capture_irq);
    rdc(`IDX_ICR1, 8'h55);
    rdc(`IDX_ICR2, 8'h66);
    rdc(`IDX_ICCSR, 8'h10);
    // Wake from halt on channel 1 only
    halt_mode <= 1'h1;
    wr(`IDX_ICCSR, 8'h14);
    pins_u.cap_set(2'h0);
    pins_u.cap_set(2'h1);
    `CHK("wake pulses", 16'h1, wakes);
    halt_mode <= 1'h0;
    // Second reset in mid-run
    rst <= 1'h1;
    cyc(2);
    rst <= 1'h0;
    rdc(`IDX_PWM_OUTPUT_CONTROL, 8'h00);
    rdc(`IDX_CAR, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
